/* File: rtl/uart_frame_format_transmitter.sv */
// Serial frame transmitter with APB register access
`timescale 1ns/1ps
module uart_frame_format_transmitter (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line
  output logic serial_out_pin,
  output logic serial_out_en,
  // Interrupt request
  output logic tx_irq
);
  import uart_tx_pkg::*;

  logic [6:0] ctrl1_q;
  logic [1:0] ctrl2_q;
  logic [7:0] baud_divisor_q;
  logic [7:0] serial_data_buffer_q;
  logic buf_full_q;
  logic [8:0] tx_shift_reg_q;
  logic tsr_full_q;
  logic tx_buffer_empty_flag_q;
  logic tx_idle_flag_q;
  logic status_seen_q;
  logic [13:0] baud_cnt_q;
  tx_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic serial_out_pin_q;
  logic serial_out_en_q;
  logic tx_irq_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // Field views
  wire word_length_sel = ctrl1_q[WORD_LENGTH_BIT];
  wire parity_type_sel = ctrl1_q[PARITY_TYPE_BIT];
  wire parity_enable = ctrl1_q[PARITY_EN_BIT];
  wire stop_count_sel = ctrl1_q[STOP_COUNT_BIT];
  wire tx_ninth_bit = ctrl1_q[NINTH_BIT];
  wire tx_enable = ctrl1_q[TX_ENABLE_BIT];
  wire break_request = ctrl1_q[BREAK_REQ_BIT];
  wire baud_high_speed_sel = ctrl2_q[HIGH_SPEED_BIT];
  wire tx_empty_irq_enable = ctrl2_q[IRQ_ENABLE_BIT];

  // Bus decode; the access edge is the only one where writes land
  wire setup_rd = psel & ~penable & ~pwrite;
  wire access = psel & penable & pready_q;
  wire hit_ctrl1 = paddr == CTRL1_OFS;
  wire hit_ctrl2 = paddr == CTRL2_OFS;
  wire hit_baud = paddr == BAUD_OFS;
  wire hit_status = paddr == STATUS_OFS;
  wire hit_data = paddr == DATA_OFS;
  wire mapped = hit_ctrl1 | hit_ctrl2 | hit_baud | hit_status | hit_data;
  wire wr_ctrl1 = access & pwrite & hit_ctrl1;
  wire wr_ctrl2 = access & pwrite & hit_ctrl2;
  wire wr_baud = access & pwrite & hit_baud;
  wire status_rd = access & ~pwrite & hit_status;
  wire data_wr = access & pwrite & hit_data & tx_buffer_empty_flag_q;
  wire seq_clear = data_wr & status_seen_q;
  wire [6:0] ctrl1_wr_val = pwdata[CTRL1_WIDTH-1:0];
  wire en_falling = wr_ctrl1 & tx_enable & ~ctrl1_wr_val[TX_ENABLE_BIT];

  wire [31:0] rd_mux =
    hit_ctrl1 ? {25'h0, ctrl1_q} :
    hit_ctrl2 ? {30'h0, ctrl2_q} :
    hit_baud ? {24'h0, baud_divisor_q} :
    hit_status ? {30'h0, tx_idle_flag_q, tx_buffer_empty_flag_q} : 32'h0;

  // divisor plus one, times 64 or 16
  // Period needs 15 bits: 256 times 64 overflows 14
  wire [14:0] n_plus_1 = {7'h0, baud_divisor_q} + 15'h1;
  wire [14:0] bit_period = baud_high_speed_sel ? (n_plus_1 << HIGH_SPEED_SHIFT)
                                               : (n_plus_1 << LOW_SPEED_SHIFT);
  wire [14:0] period_last = bit_period - 15'h1;
  wire shift_tick = {1'b0, baud_cnt_q} >= period_last;

  // Word assembly at load time from the current format
  // MSB position reused
  wire [7:0] low_data = word_length_sel ? pwdata[7:0] : {1'b0, pwdata[6:0]};
  wire par_even = ^low_data;
  wire par_bit = parity_type_sel ? ~par_even : par_even;
  logic [8:0] word_in;
  always_comb begin
    word_in = {1'b0, pwdata[7:0]};
    if (word_length_sel) begin
      word_in[8] = tx_ninth_bit;
    end
    if (parity_enable) begin
      if (word_length_sel) begin
        word_in[8] = par_bit;
      end else begin
        word_in[7] = par_bit;
      end
    end
  end
  // The buffered word is assembled the same way so parity stays consistent
  logic [8:0] word_buf_q;

  wire [3:0] last_data_bit = word_length_sel ? 4'h8 : 4'h7;
  wire [3:0] last_stop_bit = stop_count_sel ? 4'h1 : 4'h0;

  wire frame_done = shift_tick & (state_q == TX_STOP) & (bit_cnt_q == last_stop_bit);
  wire break_done = shift_tick & (state_q == TX_BREAK) & (bit_cnt_q == BREAK_UNIT_BITS)
                    & ~break_request;
  wire direct_load = data_wr & tx_enable & ~tsr_full_q;
  wire buf_load = data_wr & ~direct_load;
  wire reload = buf_full_q & tx_enable & ~tsr_full_q & ~direct_load;

  // APB answer: no wait states, read data captured in setup
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~mapped;
      prdata_q <= setup_rd ? rd_mux : 32'h0;
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl1_q <= CTRL1_RST;
      ctrl2_q <= CTRL2_RST;
      baud_divisor_q <= BAUD_RST;
    end else begin
      if (wr_ctrl1) begin
        ctrl1_q <= ctrl1_wr_val;
      end
      if (wr_ctrl2) begin
        ctrl2_q <= pwdata[1:0];
      end
      if (wr_baud) begin
        baud_divisor_q <= pwdata[7:0];
      end
    end
  end

  // Status-access tracking for the clear sequence
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_seen_q <= 1'b0;
    end else if (status_rd) begin
      status_seen_q <= 1'b1;
    end else if (data_wr) begin
      status_seen_q <= 1'b0;
    end
  end

  // Free-running bit-period timer
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      baud_cnt_q <= 14'h0;
    end else if (shift_tick) begin
      baud_cnt_q <= 14'h0;
    end else begin
      baud_cnt_q <= baud_cnt_q + 14'h1;
    end
  end

  // Holding buffer; data written while disabled waits here for the enable
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_data_buffer_q <= 8'h00;
      word_buf_q <= 9'h000;
      buf_full_q <= 1'b0;
    end else if (buf_load) begin
      serial_data_buffer_q <= pwdata[7:0];
      word_buf_q <= word_in;
      buf_full_q <= 1'b1;
    end else if (reload) begin
      buf_full_q <= 1'b0;
    end
  end

  // Flags: hardware set takes priority over the software sequence
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_buffer_empty_flag_q <= 1'b1;
      tx_idle_flag_q <= 1'b1;
    end else begin
      if (seq_clear) begin
        tx_buffer_empty_flag_q <= 1'b0;
        tx_idle_flag_q <= 1'b0;
      end
      if (direct_load | reload) begin
        tx_buffer_empty_flag_q <= 1'b1;
      end
      if (frame_done | (en_falling & (state_q != TX_IDLE))) begin
        tx_idle_flag_q <= 1'b1;
      end
    end
  end

  // Transmit sequencer
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= TX_IDLE;
      bit_cnt_q <= 4'h0;
      tx_shift_reg_q <= 9'h000;
      tsr_full_q <= 1'b0;
      serial_out_pin_q <= 1'b1;
    end else if (!tx_enable) begin
      state_q <= TX_IDLE;
      bit_cnt_q <= 4'h0;
      tsr_full_q <= 1'b0;
      serial_out_pin_q <= 1'b1;
    end else begin
      if (direct_load) begin
        tx_shift_reg_q <= word_in;
        tsr_full_q <= 1'b1;
      end else if (reload) begin
        tx_shift_reg_q <= word_buf_q;
        tsr_full_q <= 1'b1;
      end
      if (shift_tick) begin
        case (state_q)
          TX_IDLE: begin
            serial_out_pin_q <= 1'b1;
            bit_cnt_q <= 4'h0;
            if (break_request) begin
              state_q <= TX_BREAK;
              serial_out_pin_q <= 1'b0;
            end else if (tsr_full_q) begin
              state_q <= TX_START;
              serial_out_pin_q <= 1'b0;
            end
          end
          TX_START: begin
            state_q <= TX_DATA;
            serial_out_pin_q <= tx_shift_reg_q[0];
            tx_shift_reg_q <= {1'b0, tx_shift_reg_q[8:1]};
          end
          TX_DATA: begin
            if (bit_cnt_q == last_data_bit) begin
              state_q <= TX_STOP;
              bit_cnt_q <= 4'h0;
              serial_out_pin_q <= 1'b1;
            end else begin
              bit_cnt_q <= bit_cnt_q + 4'h1;
              serial_out_pin_q <= tx_shift_reg_q[0];
              tx_shift_reg_q <= {1'b0, tx_shift_reg_q[8:1]};
            end
          end
          TX_STOP: begin
            serial_out_pin_q <= 1'b1;
            if (bit_cnt_q == last_stop_bit) begin
              state_q <= TX_IDLE;
              bit_cnt_q <= 4'h0;
              tsr_full_q <= 1'b0;
            end else begin
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
          TX_BREAK: begin
            if (bit_cnt_q == BREAK_UNIT_BITS) begin
              bit_cnt_q <= 4'h1;
              if (!break_request) begin
                state_q <= TX_STOP;
                bit_cnt_q <= 4'h0;
                serial_out_pin_q <= 1'b1;
              end
            end else begin
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
          default: begin
            state_q <= TX_IDLE;
          end
        endcase
      end
    end
  end

  // Pin ownership and interrupt; a break in progress suppresses the request
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_out_en_q <= 1'b0;
      tx_irq_q <= 1'b0;
    end else begin
      serial_out_en_q <= tx_enable;
      tx_irq_q <= tx_empty_irq_enable & tx_buffer_empty_flag_q & (state_q != TX_BREAK);
    end
  end

  // Outputs driven straight from their registers, carried unchanged
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign serial_out_pin = serial_out_pin_q;
  assign serial_out_en = serial_out_en_q;
  assign tx_irq = tx_irq_q;

endmodule : uart_frame_format_transmitter

/* File: common/uart_tx_pkg.sv */
// Constants, register map and field layout of the serial frame transmitter
package uart_tx_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL1_OFS = 8'h00;
  localparam logic [7:0] CTRL2_OFS = 8'h04;
  localparam logic [7:0] BAUD_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] DATA_OFS = 8'h10;

  // serial_control_reg1 fields
  localparam int WORD_LENGTH_BIT = 0;
  localparam int PARITY_TYPE_BIT = 1;
  localparam int PARITY_EN_BIT = 2;
  localparam int STOP_COUNT_BIT = 3;
  localparam int NINTH_BIT = 4;
  localparam int TX_ENABLE_BIT = 5;
  localparam int BREAK_REQ_BIT = 6;
  localparam int CTRL1_WIDTH = 7;

  // serial_control_reg2 fields
  localparam int HIGH_SPEED_BIT = 0;
  localparam int IRQ_ENABLE_BIT = 1;

  // serial_status_reg fields
  localparam int BUF_EMPTY_BIT = 0;
  localparam int IDLE_BIT = 1;

  // Reset values: 8 data bits, no parity, one stop bit, transmitter off
  localparam logic [6:0] CTRL1_RST = 7'h00;
  localparam logic [1:0] CTRL2_RST = 2'h0;
  localparam logic [7:0] BAUD_RST = 8'h00;

  // Bit-period prescale shifts: 64 in low-speed mode, 16 in high-speed mode
  localparam int LOW_SPEED_SHIFT = 6;
  localparam int HIGH_SPEED_SHIFT = 4;

  // Break-unit end count: the first unit holds 14 zero bits, later ones 13
  localparam logic [3:0] BREAK_UNIT_BITS = 4'hD;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_START,
    TX_DATA,
    TX_STOP,
    TX_BREAK
  } tx_state_t;

endpackage : uart_tx_pkg

/* File: sim/uart_tx_props.sv */
// Port-level checker for the serial frame transmitter
`timescale 1ns/1ps
module uart_tx_props
  import uart_tx_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Line and interrupt
  input wire logic serial_out_pin,
  input wire logic serial_out_en,
  input wire logic tx_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire bad_addr = (paddr > DATA_OFS) || (paddr[1:0] != 2'b00);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_read(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  property p_ready_next; s_setup |=> pready && psel && penable; endproperty
  a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
  property p_ready_one; pready |=> !pready; endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready held too long");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_rdata_zero; !pready |-> prdata == 32'h0; endproperty
  a_rdata_zero: assert property (p_rdata_zero) else $error("read data outside access");
  property p_unmapped; s_setup ##0 bad_addr |=> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped address accepted");
  property p_mapped; s_setup ##0 !bad_addr |=> !pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped address refused");
  property p_data_wo; s_read(DATA_OFS) |=> prdata == 32'h0; endproperty
  a_data_wo: assert property (p_data_wo) else $error("data register not write-only");
  property p_status_hi; s_read(STATUS_OFS) |=> prdata[31:2] == 30'h0; endproperty
  a_status_hi: assert property (p_status_hi) else $error("status upper bits set");
  property p_idle_high; !serial_out_en |-> serial_out_pin; endproperty
  a_idle_high: assert property (p_idle_high) else $error("pin low while released");
  property p_min_bit;
    $fell(serial_out_pin) |-> serial_out_en ##1 (!serial_out_pin || !serial_out_en) [*8];
  endproperty
  a_min_bit: assert property (p_min_bit) else $error("bit shorter than minimum");
endmodule : uart_tx_props
bind uart_frame_format_transmitter uart_tx_props chk_i (.core_clk(core_clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_out_pin(serial_out_pin),
  .serial_out_en(serial_out_en), .tx_irq(tx_irq));

/* File: sim/serial_rx_model.sv */
// Line receiver model sampling mid-bit at sixteen cycles a bit
`timescale 1ns/1ps
module serial_rx_model (
  // Clock
  input wire logic core_clk,
  // Line and format
  input wire logic line,
  input wire logic [3:0] nbits,
  input wire logic two_stop,
  // Capture
  output logic [8:0] word,
  output int frames,
  output int stop_err
);
  initial begin
    word = 9'h000;
    frames = 0;
    stop_err = 0;
    forever begin
      @(negedge line);
      repeat (8) @(posedge core_clk);
      if (line === 1'b0) begin
        word = 9'h000;
        for (int i = 0; i < nbits; i++) begin
          repeat (16) @(posedge core_clk);
          word[i] = line;
        end
        for (int s = 0; s <= two_stop; s++) begin
          repeat (16) @(posedge core_clk);
          if (line !== 1'b1) stop_err++;
        end
        frames++;
      end
    end
  end
endmodule : serial_rx_model

/* File: sim/tb_uart_frame_format_transmitter.sv */
// Self-checking bench for the serial frame transmitter
`timescale 1ns/1ps
module tb_uart_frame_format_transmitter;
  import uart_tx_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, serial_out_pin, serial_out_en, tx_irq, e;
  logic [3:0] nbits = 4'h8;
  logic two_stop = 1'b0;
  logic [8:0] word;
  int frames, stop_err, f0;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  int low_run = 0;
  int max_low = 0;
  logic [7:0] cfg [5] = '{8'h24, 8'h26, 8'h31, 8'h29, 8'h25};
  logic [7:0] dat [5] = '{8'h13, 8'h93, 8'h5A, 8'h3C, 8'h07};
  logic [8:0] expw [5] = '{9'h093, 9'h013, 9'h15A, 9'h03C, 9'h107};
  always #2.5 core_clk = ~core_clk;
  uart_frame_format_transmitter uut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_out_pin(serial_out_pin),
    .serial_out_en(serial_out_en), .tx_irq(tx_irq));
  serial_rx_model rx (.core_clk(core_clk), .line(serial_out_pin), .nbits(nbits),
    .two_stop(two_stop), .word(word), .frames(frames), .stop_err(stop_err));
  // Longest low run on the line, for break length
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    low_run <= serial_out_pin ? 0 : low_run + 1;
    if (low_run > max_low) max_low <= low_run;
    if (cycles == 40000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("Counts: %0d mismatches, %0d comparisons", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, q);
  endtask : rd
  // Status access then data write, as software must
  task automatic send(input logic [31:0] d);
    apb(1'b0, STATUS_OFS, 32'h0);
    apb(1'b1, DATA_OFS, d);
  endtask : send
  task automatic wait_frames(input int n);
    for (int i = 0; i < 4000 && frames < n; i++) @(posedge core_clk);
    chk("frames", n, frames);
  endtask : wait_frames
  task automatic wait_low();
    for (int i = 0; i < 2000 && serial_out_pin !== 1'b0; i++) @(posedge core_clk);
  endtask : wait_low
  initial begin
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rd(CTRL1_OFS, 32'h0, "ctrl1_reset");
    rd(STATUS_OFS, 32'h3, "status_reset");
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, e});
    $display("test registers done");
    apb(1'b1, BAUD_OFS, 32'h0);
    apb(1'b1, CTRL2_OFS, 32'h1);
    send(32'hA5);
    apb(1'b1, CTRL1_OFS, 32'h20);
    wait_frames(1);
    chk("word_8n1", 32'hA5, {23'h0, word});
    for (int k = 0; k < 5; k++) begin
      nbits = cfg[k][0] ? 4'h9 : 4'h8;
      two_stop = cfg[k][3];
      apb(1'b1, CTRL1_OFS, {24'h0, cfg[k]});
      send({24'h0, dat[k]});
      wait_frames(k + 2);
      chk("word_format", {23'h0, expw[k]}, {23'h0, word});
    end
    chk("stop_err", 32'h0, stop_err);
    $display("test formats done");
    nbits = 4'h8;
    two_stop = 1'b0;
    apb(1'b1, CTRL1_OFS, 32'h20);
    f0 = frames;
    send(32'h11);
    rd(STATUS_OFS, 32'h1, "status_direct");
    send(32'h22);
    rd(STATUS_OFS, 32'h0, "status_held");
    apb(1'b1, DATA_OFS, 32'h33);
    wait_frames(f0 + 2);
    chk("word_held", 32'h22, {23'h0, word});
    repeat (400) @(posedge core_clk);
    chk("frames_blocked", f0 + 2, frames);
    rd(STATUS_OFS, 32'h3, "status_done");
    $display("test buffer done");
    apb(1'b1, CTRL2_OFS, 32'h3);
    @(negedge core_clk);
    chk("irq_on", 32'h1, {31'h0, tx_irq});
    @(posedge core_clk);
    send(32'h44);
    send(32'h55);
    @(negedge core_clk);
    chk("irq_full", 32'h0, {31'h0, tx_irq});
    @(posedge core_clk);
    wait_frames(f0 + 4);
    @(negedge core_clk);
    chk("irq_again", 32'h1, {31'h0, tx_irq});
    @(posedge core_clk);
    $display("test interrupt done");
    apb(1'b1, CTRL1_OFS, 32'h60);
    send(32'h00);
    wait_low();
    repeat (40) @(posedge core_clk);
    @(negedge core_clk);
    chk("irq_break", 32'h0, {31'h0, tx_irq});
    @(posedge core_clk);
    apb(1'b1, CTRL1_OFS, 32'h20);
    repeat (1000) @(posedge core_clk);
    chk("break_min", 32'h1, {31'h0, max_low >= 224});
    chk("break_one", 32'h1, {31'h0, max_low < 240});
    $display("test break done");
    send(32'h0F);
    wait_low();
    repeat (40) @(posedge core_clk);
    apb(1'b1, CTRL1_OFS, 32'h00);
    @(negedge core_clk);
    chk("pin_abort", 32'h1, {31'h0, serial_out_pin});
    chk("en_abort", 32'h0, {31'h0, serial_out_en});
    @(posedge core_clk);
    rd(STATUS_OFS, 32'h3, "status_abort");
    $display("test abort done");
    end_sim();
  end
endmodule : tb_uart_frame_format_transmitter
